// >>> core/adc_seq_timing.sv
// conversion sequence timing control with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.svh"
module adc_seq_timing
   import adc_seq_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic CLK_SYS_I,
   input wire logic RSTN_I,
   input wire logic BREAKPOINT_I,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   output logic CONV_CLK_O,
   output logic SAMPLE_O,
   output logic CONVERT_O,
   output logic SEQ_BUSY_O,
   output logic SEQ_DONE_O,
   output logic [3:0] CONV_INDEX_O
);
   // refuse address widths the word decode cannot serve
   if (ADDR_W < 3 || ADDR_W > 32) begin : addr_w_check_g
      $error("ADDR_W out of range");
   end

   //------------------------------------------------------------
   // reset release
   //------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   //------------------------------------------------------------
   // axi4-lite write path
   //------------------------------------------------------------
   logic aw_have_reg;
   logic w_have_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic w_strb0_reg;
   logic bvalid_reg;
   logic bresp_err_reg;
   logic wr_fire;
   logic [31:0] wr_addr;
   assign S_AXI_AWREADY_O = !aw_have_reg && !bvalid_reg;
   assign S_AXI_WREADY_O = !w_have_reg && !bvalid_reg;
   assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
   assign wr_addr = 32'(aw_addr_reg);
   always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 32'h0000_0000;
         w_strb0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_err_reg <= 1'b0;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR_I;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_have_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA_I;
            w_strb0_reg <= S_AXI_WSTRB_I[0];
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            // format, timing, start and status answer okay, all else an error
            bresp_err_reg <= wr_addr[31:2] < 30'(`OFS_FORMAT_CTRL)
               || wr_addr[31:2] > 30'(`OFS_STATUS);
         end else if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O = bresp_err_reg ? 2'b10 : 2'b00;

   //------------------------------------------------------------
   // registers, indexed: byte address is four times the offset
   //------------------------------------------------------------
   logic [7:0] format_reg;
   logic [7:0] timing_reg;
   logic start_pulse;
   logic abort_pulse;
   logic wr_format;
   logic wr_timing;
   assign wr_format = wr_fire && w_strb0_reg && wr_addr[31:2] == 30'(`OFS_FORMAT_CTRL);
   assign wr_timing = wr_fire && w_strb0_reg && wr_addr[31:2] == 30'(`OFS_TIMING_CTRL);
   assign start_pulse = wr_fire && w_strb0_reg && wr_addr[31:2] == 30'(`OFS_START_CTRL);
   assign abort_pulse = wr_timing || wr_format || start_pulse; // see R03
   always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         format_reg <= `FORMAT_RESET; // see R06
         timing_reg <= `TIMING_RESET;
      end else begin
         if (wr_format) format_reg <= w_data_reg[7:0];
         if (wr_timing) timing_reg <= w_data_reg[7:0];
      end
   end

   //------------------------------------------------------------
   // field decode
   //------------------------------------------------------------
   logic [3:0] len_code;
   logic [3:0] seq_len;
   halt_mode_t halt_mode;
   logic [4:0] prs;
   logic [4:0] smp_cycles;
   assign len_code = format_reg[`LEN_MSB:`LEN_LSB]; // see R07
   assign halt_mode = halt_mode_t'(format_reg[`HALT_MSB:`HALT_LSB]); // see R08
   assign prs = timing_reg[`PRS_MSB:`PRS_LSB];
   // codes 1..9 are the count, the rest ten
   assign seq_len = (len_code == `MAX_CONV || len_code > 4'h9) ? `TEN_CONV : len_code; // see R01
   always_comb begin
      case (timing_reg[`SMP_MSB:`SMP_LSB]) // see R05
         3'h0: smp_cycles = `SMP_CYC_0;
         3'h1: smp_cycles = `SMP_CYC_1;
         3'h2: smp_cycles = `SMP_CYC_2;
         3'h3: smp_cycles = `SMP_CYC_3;
         3'h4: smp_cycles = `SMP_CYC_4;
         3'h5: smp_cycles = `SMP_CYC_5;
         3'h6: smp_cycles = `SMP_CYC_6;
         default: smp_cycles = `SMP_CYC_7;
      endcase
   end

   //------------------------------------------------------------
   // prescaler: half period of prs+1 bus clocks
   //------------------------------------------------------------
   logic [4:0] div_cnt_reg;
   logic conv_clk_reg;
   logic tick;
   logic freeze;
   assign tick = div_cnt_reg >= prs && !conv_clk_reg && !freeze; // rising edge of conversion clock
   always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         div_cnt_reg <= 5'h00;
         conv_clk_reg <= 1'b0;
      end else if (abort_pulse) begin
         div_cnt_reg <= 5'h00;
         conv_clk_reg <= 1'b0;
      end else if (!freeze) begin
         if (div_cnt_reg >= prs) begin // see R04
            div_cnt_reg <= 5'h00;
            conv_clk_reg <= !conv_clk_reg;
         end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
         end
      end
   end
   assign CONV_CLK_O = conv_clk_reg;

   //------------------------------------------------------------
   // sequencer
   //------------------------------------------------------------
   seq_state_t state_reg;
   logic [4:0] phase_cnt_reg;
   logic [3:0] conv_idx_reg;
   logic done_reg;
   // immediate freeze stops the prescaler and sequencer while the breakpoint is high; a format, timing or start write still aborts
   assign freeze = BREAKPOINT_I && halt_mode == HALT_NOW; // see R02
   always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg <= ST_IDLE;
         phase_cnt_reg <= 5'h00;
         conv_idx_reg <= 4'h0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start_pulse) begin
            state_reg <= ST_SAMPLE;
            phase_cnt_reg <= 5'h00;
            conv_idx_reg <= 4'h0;
         end else if (abort_pulse) begin
            state_reg <= ST_IDLE; // see R03
            phase_cnt_reg <= 5'h00;
            conv_idx_reg <= 4'h0;
         end else begin
            case (state_reg)
               ST_SAMPLE: begin
                  if (tick) begin
                     if (phase_cnt_reg == smp_cycles - 5'h01) begin // see R09
                        state_reg <= ST_CONVERT;
                        phase_cnt_reg <= 5'h00;
                     end else begin
                        phase_cnt_reg <= phase_cnt_reg + 5'h01;
                     end
                  end
               end
               ST_CONVERT: begin
                  if (tick) begin
                     if (phase_cnt_reg == `CONV_CYCLES - 5'h01) begin
                        phase_cnt_reg <= 5'h00;
                        if (conv_idx_reg == seq_len - 4'h1) begin
                           state_reg <= ST_IDLE;
                           done_reg <= 1'b1;
                           conv_idx_reg <= 4'h0;
                        end else begin
                           conv_idx_reg <= conv_idx_reg + 4'h1;
                           // finish-then-halt stops after this conversion
                           state_reg <= (BREAKPOINT_I && halt_mode == HALT_FINISH)
                              ? ST_HALTED : ST_SAMPLE; // see R02
                        end
                     end else begin
                        phase_cnt_reg <= phase_cnt_reg + 5'h01;
                     end
                  end
               end
               ST_HALTED: begin
                  if (!(BREAKPOINT_I && halt_mode == HALT_FINISH)) state_reg <= ST_SAMPLE;
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end
   assign SAMPLE_O = state_reg == ST_SAMPLE;
   assign CONVERT_O = state_reg == ST_CONVERT;
   assign SEQ_BUSY_O = state_reg != ST_IDLE;
   assign SEQ_DONE_O = done_reg;
   assign CONV_INDEX_O = conv_idx_reg;

   //------------------------------------------------------------
   // axi4-lite read path
   //------------------------------------------------------------
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic rresp_err_reg;
   logic [31:0] rd_addr;
   assign rd_addr = 32'(S_AXI_ARADDR_I);
   assign S_AXI_ARREADY_O = !rvalid_reg;
   always_ff @(posedge CLK_SYS_I or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_err_reg <= 1'b0;
      end else if (S_AXI_ARVALID_I && !rvalid_reg) begin
         rvalid_reg <= 1'b1;
         rresp_err_reg <= 1'b0;
         if (rd_addr[31:2] == 30'(`OFS_FORMAT_CTRL)) begin
            rdata_reg <= {24'h00_0000, format_reg};
         end else if (rd_addr[31:2] == 30'(`OFS_TIMING_CTRL)) begin
            rdata_reg <= {24'h00_0000, timing_reg};
         end else if (rd_addr[31:2] == 30'(`OFS_START_CTRL)) begin
            rdata_reg <= 32'h0000_0000;
         end else if (rd_addr[31:2] == 30'(`OFS_STATUS)) begin
            rdata_reg <= {22'h0, state_reg, conv_idx_reg, seq_len};
         end else begin
            rdata_reg <= 32'h0000_0000;
            rresp_err_reg <= 1'b1;
         end
      end else if (rvalid_reg && S_AXI_RREADY_I) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_RDATA_O = rdata_reg;
   assign S_AXI_RRESP_O = rresp_err_reg ? 2'b10 : 2'b00;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   timing_abort_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R03
      wr_timing |=> state_reg == ST_IDLE) else $error("timing write did not abort");
   reset_len_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R06
      $rose(rst_n_reg) |-> seq_len == 4'h4) else $error("reset length not four");
   len_decode_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R01
      seq_len == ((len_code >= 4'h1 && len_code <= 4'h9) ? len_code : 4'ha))
      else $error("length decode wrong");
   half_period_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R04
      $rose(conv_clk_reg) && !abort_pulse && prs == 5'h00 && !freeze |=> !conv_clk_reg)
      else $error("prescale zero half period wrong");
   freeze_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R02
      freeze && !abort_pulse |=> $stable(conv_clk_reg)) else $error("clock moved in freeze");
   smp_four_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R05
      timing_reg[7:5] == 3'h0 |-> smp_cycles == 5'h04) else $error("sample code zero");
   sample_end_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R09
      $rose(state_reg == ST_CONVERT) |-> $past(state_reg) == ST_SAMPLE && $past(tick)
      && $past(phase_cnt_reg) == smp_cycles - 5'h01)
      else $error("convert entered before sample count ended");
   sample_len_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) // see R09
      state_reg == ST_SAMPLE && tick && phase_cnt_reg != smp_cycles - 5'h01 && !abort_pulse
      |=> state_reg == ST_SAMPLE) else $error("sample phase cut short");
   start_cov_c: cover property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) start_pulse);
   done_cov_c: cover property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) done_reg);
   halt_cov_c: cover property (@(posedge CLK_SYS_I) disable iff (!rst_n_reg) state_reg == ST_HALTED);
endmodule : adc_seq_timing
`default_nettype wire

// >>> core/adc_seq_consts.svh
// constants for the conversion sequence timing control block
//------------------------------------------------------------
// What this block does
// R01 - length codes 1..9 direct, others give ten
// R02 - breakpoint halt: continue, finish-then-halt, immediate
// R03 - timing register write aborts running sequence
// R04 - conversion clock is bus over 2*(prescale+1)
// R05 - sample length code selects 4..24 cycles
// R06 - sequence length resets to four conversions
// R07 - sequence length sits in format bits 6..3
// R08 - halt select sits in format bits 1..0
// R09 - sample phase counted in conversion clocks first
//------------------------------------------------------------
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define OFS_FORMAT_CTRL 32'h0000_0003
`define OFS_TIMING_CTRL 32'h0000_0004
`define OFS_START_CTRL 32'h0000_0005
`define OFS_STATUS 32'h0000_0006
`define FORMAT_RESET 8'h20
`define TIMING_RESET 8'h05
`define LEN_LSB 3
`define LEN_MSB 6
`define HALT_LSB 0
`define HALT_MSB 1
`define PRS_LSB 0
`define PRS_MSB 4
`define SMP_LSB 5
`define SMP_MSB 7
`define MAX_CONV 4'h0
`define TEN_CONV 4'ha
`define CONV_CYCLES 5'h0a
`define SMP_CYC_0 5'h04
`define SMP_CYC_1 5'h06
`define SMP_CYC_2 5'h08
`define SMP_CYC_3 5'h0a
`define SMP_CYC_4 5'h0c
`define SMP_CYC_5 5'h10
`define SMP_CYC_6 5'h14
`define SMP_CYC_7 5'h18
`endif

// >>> core/adc_seq_pkg.sv
// types shared by the conversion sequence timing block
package adc_seq_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_HALTED} seq_state_t;
   typedef enum logic [1:0] {HALT_CONTINUE, HALT_RESERVED, HALT_FINISH, HALT_NOW} halt_mode_t;
endpackage : adc_seq_pkg

// >>> bench/adc_sequence_timing_control_tb_top.sv
// self-checking testbench for the conversion sequence timing block
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_timing_control_tb_top;
   import adc_seq_pkg::*;
   logic clk, rstn, brk, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, conv_clk, sample, convert, busy, done;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb, idx;
   logic [1:0] bresp, rresp, rsp;
   logic clk_seen;
   int n_errors, checks, cnt, per, last, t, k, prs, nconv;
   int smp_len[8] = '{4, 6, 8, 10, 12, 16, 20, 24};

   adc_seq_timing #(.ADDR_W(8)) dut_u (.CLK_SYS_I(clk), .RSTN_I(rstn), .BREAKPOINT_I(brk),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .CONV_CLK_O(conv_clk),
      .SAMPLE_O(sample), .CONVERT_O(convert), .SEQ_BUSY_O(busy), .SEQ_DONE_O(done),
      .CONV_INDEX_O(idx));

   //------------------------------------------------------------
   // clock and shared tasks
   //------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // bounds every wait loop; running out ends the run
   task automatic guard(inout int n);
      n++;
      if (n > 6000) begin
         n_errors++;
         report_and_stop();
      end
   endtask : guard

   // one write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_go, w_go, aw_done, w_done;
      n = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge clk);
         aw_go = awvalid && awready;
         w_go = wvalid && wready;
         guard(n);
         @(posedge clk);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         aw_done = aw_done | aw_go;
         w_done = w_done | w_go;
      end
      do begin
         @(negedge clk);
         guard(n);
      end while (!bvalid);
      r = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask : axi_wr

   // one read: address held until taken, then wait for the data
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic go;
      n = 0;
      go = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!go) begin
         @(negedge clk);
         go = arvalid && arready;
         guard(n);
         @(posedge clk);
         if (go) arvalid <= 1'b0;
      end
      while (!rvalid) begin
         @(negedge clk);
         guard(n);
      end
      d = rdata;
      r = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask : axi_rd

   // waits for sample, convert, busy or done to reach a level
   task automatic wait_for(input int w, input logic lvl);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         guard(n);
      end while ((w == 0 ? sample : w == 1 ? convert : w == 2 ? busy : done) !== lvl);
   endtask : wait_for

   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      {rstn, brk, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      n_errors = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      // reset values and an unmapped place
      axi_rd(8'h0c, rd, rsp);
      check(rd, 32'h0000_0020);
      axi_rd(8'h10, rd, rsp);
      check(rd, 32'h0000_0005);
      axi_rd(8'h18, rd, rsp);
      check(rd[3:0], 32'h0000_0004);
      axi_rd(8'h20, rd, rsp);
      check(rsp, 32'h0000_0002);
      check(rd, 32'h0000_0000);
      // a write without its low strobe lands nowhere, an unmapped one is refused
      wstrb <= 4'h0;
      axi_wr(8'h10, 32'h0000_00ff, rsp);
      wstrb <= 4'hf;
      check(rsp, 32'h0000_0000);
      axi_rd(8'h10, rd, rsp);
      check(rd, 32'h0000_0005);
      axi_wr(8'h20, 32'h0000_00ff, rsp);
      check(rsp, 32'h0000_0002);
      // every length code decoded into the status register
      for (k = 0; k < 16; k++) begin
         axi_wr(8'h0c, k << 3, rsp);
         axi_rd(8'h18, rd, rsp);
         check(rd[3:0], (k >= 1 && k <= 9) ? k : 10);
      end
      // conversions actually run for three lengths
      axi_wr(8'h10, 32'h0000_0000, rsp);
      foreach (smp_len[i]) if (i < 3) begin
         t = (i == 0) ? 1 : (i == 1) ? 9 : 0;
         axi_wr(8'h0c, t << 3, rsp);
         axi_wr(8'h14, 32'h0000_0001, rsp);
         nconv = 0;
         cnt = 0;
         last = 0;
         do begin
            @(negedge clk);
            if (convert && !last) nconv++;
            last = convert;
            guard(cnt);
         end while (!done);
         check(nconv, (t == 0) ? 10 : t);
      end
      // sample length per code and conversion clock period per prescale
      axi_wr(8'h0c, 32'h0000_0008, rsp);
      for (k = 0; k < 8; k++) begin
         prs = (k == 7) ? 31 : k;
         axi_wr(8'h10, (k << 5) | prs, rsp);
         axi_wr(8'h14, 32'h0000_0001, rsp);
         wait_for(0, 1'b1);
         // with prescale zero the first rise comes before the loop looks
         cnt = int'(conv_clk);
         per = 0;
         last = int'(conv_clk);
         t = 0;
         nconv = 0;
         while (!convert) begin
            @(negedge clk);
            t++;
            if (conv_clk && !last) begin
               cnt++;
               if (cnt == 3) per = t;
               t = 0;
            end
            last = conv_clk;
            guard(nconv);
         end
         check(cnt, smp_len[k]);
         check(per, 2 * (prs + 1));
         wait_for(2, 1'b0);
      end
      // timing write in mid-sequence abandons it
      axi_wr(8'h10, 32'h0000_0000, rsp);
      axi_wr(8'h0c, 32'h0000_0000, rsp);
      axi_wr(8'h14, 32'h0000_0001, rsp);
      wait_for(1, 1'b1);
      axi_wr(8'h10, 32'h0000_0000, rsp);
      @(negedge clk);
      check(busy, 1'b0);
      // breakpoint under each halt setting
      for (k = 0; k < 4; k++) begin
         axi_wr(8'h0c, (2 << 3) | k, rsp);
         axi_wr(8'h14, 32'h0000_0001, rsp);
         wait_for(1, 1'b1);
         @(posedge clk);
         brk <= 1'b1;
         repeat (2) @(posedge clk);
         @(negedge clk);
         check(convert, 1'b1);
         if (k < 2) begin
            wait_for(3, 1'b1);
         end else if (k == 2) begin
            wait_for(1, 1'b0);
            repeat (4) @(negedge clk);
            check({busy, sample, convert}, 3'b100);
            check(idx, 32'h0000_0001);
            axi_rd(8'h18, rd, rsp);
            check(rd[9:8], 32'(ST_HALTED));
            check(rd[7:4], 32'h0000_0001);
         end else begin
            // frozen: longer than a conversion, yet nothing moves
            clk_seen = conv_clk;
            repeat (40) @(negedge clk);
            check({busy, sample, convert, conv_clk}, {3'b101, clk_seen});
            axi_rd(8'h18, rd, rsp);
            check(rd[9:8], 32'(ST_CONVERT));
         end
         @(posedge clk);
         brk <= 1'b0;
         wait_for(2, 1'b0);
      end
      report_and_stop();
   end
endmodule : adc_sequence_timing_control_tb_top
`default_nettype wire
